// ===== common/fabric_params.svh
// Dimensions, configuration word layout and fixed indices of the fabric.
`ifndef FABRIC_PARAMS_SVH
`define FABRIC_PARAMS_SVH

`define ROWS           4
`define COLS           4
`define TRACKS         5
`define VLONG          3
`define HLONG          2
`define EDGES          4
`define IO_PER_EDGE    4
`define EDGE_CLKS      2
`define PINS           4
`define SPLIT_LINES    2
`define ALT_VLONG      2
`define COLUMN_VLONG   0
`define SMALLEST_ARRAY 1'h0
`define EDGE_TOP       0
`define EDGE_RIGHT     1
`define EDGE_BOTTOM    2
`define EDGE_LEFT      3
`define PIN_A          0
`define PIN_B          1
`define PIN_C          2
`define PIN_D          3
`define CFG_WORD_W     16
`define CFG_ADDR_W     6
`define CFG_RESET      16'h0000
`define KEEPER_RESET   1'h0

`endif

// ===== common/fabric_pkg.sv
// Types shared by the routing fabric, its configuration store and testbench.
`include "fabric_params.svh"

package fabric_pkg;

  typedef enum logic [2:0] {
    SEG_OPEN       = 3'h0,
    SEG_FROM_LOW   = 3'h1,
    SEG_FROM_HIGH  = 3'h2,
    SEG_FROM_X     = 3'h3,
    SEG_FROM_Y     = 3'h4,
    SEG_FROM_CROSS = 3'h5
  } seg_src_e;

  typedef enum logic [1:0] {
    PIN_OPEN   = 2'h0,
    PIN_DIRECT = 2'h1,
    PIN_HSEG   = 2'h2,
    PIN_LONG   = 2'h3
  } pin_src_e;

  typedef enum logic [1:0] {
    CLK_NONE      = 2'h0,
    CLK_GLOBAL    = 2'h1,
    CLK_ALTERNATE = 2'h2,
    CLK_COLUMN    = 2'h3
  } clk_src_e;

  typedef enum logic [1:0] {
    VLL_FROM_X  = 2'h0,
    VLL_FROM_Y  = 2'h1,
    VLL_FROM_IO = 2'h2
  } vll_src_e;

  typedef struct packed {
    pin_src_e   src;
    logic [2:0] idx;
  } pin_cfg_s;

  typedef struct packed {
    pin_cfg_s [`PINS-1:0]   pin;
    clk_src_e               clk;
    logic [`HLONG-1:0]      tbuf_use;
    logic                   vll_en;
    logic [1:0]             vll_line;
    vll_src_e               vll_src;
    seg_src_e [`TRACKS-1:0] hseg;
    seg_src_e [`TRACKS-1:0] vseg;
  } blk_cfg_s;

  typedef struct packed {
    logic [`SPLIT_LINES-1:0] split;
    logic                    alt_link;
  } col_cfg_s;

  typedef struct packed {
    logic [`HLONG-1:0][1:0] end_pull;
  } row_cfg_s;

  typedef struct packed {
    logic [`EDGE_CLKS-1:0]   gclk_drive;
    logic [`IO_PER_EDGE-1:0] io_direct;
  } edge_cfg_s;

  typedef struct packed {
    blk_cfg_s [`ROWS-1:0][`COLS-1:0] blk;
    col_cfg_s [`COLS-1:0]            col;
    row_cfg_s [`ROWS-1:0]            row;
    edge_cfg_s [`EDGES-1:0]          edges;
  } config_s;

  typedef struct packed {
    logic              x;
    logic              y;
    logic [`HLONG-1:0] tbuf_data;
    logic [`HLONG-1:0] tbuf_ctl_n;
  } blk_out_s;

  typedef struct packed {
    logic [`PINS-1:0] pin;
    logic             k;
  } blk_in_s;

  typedef blk_out_s [`ROWS-1:0][`COLS-1:0]           blk_out_t;
  typedef blk_in_s [`ROWS-1:0][`COLS-1:0]            blk_in_t;
  typedef logic [`EDGES-1:0][`IO_PER_EDGE-1:0]       io_t;
  typedef logic [`EDGES-1:0][`EDGE_CLKS-1:0]         edge_clk_t;
  typedef logic [`ROWS-1:0][`HLONG-1:0]              hll_t;

endpackage : fabric_pkg

// ===== design/cfg_store.sv
// Configuration memory of the fabric, written word by word, cleared on reset.
`timescale 1ns/100ps
`include "fabric_params.svh"

module cfg_store (
  input  wire logic                     clock,
  input  wire logic                     rst,
  input  wire logic                     wr_en,
  input  wire logic [`CFG_ADDR_W-1:0]   addr,
  input  wire logic [`CFG_WORD_W-1:0]   wr_data,
  output logic      [`CFG_WORD_W-1:0]   rd_data,
  output fabric_pkg::config_s           cfg
);

  localparam int CFG_BITS = $bits(fabric_pkg::config_s);
  localparam int WORDS    = (CFG_BITS + `CFG_WORD_W - 1) / `CFG_WORD_W;

  typedef struct packed {
    logic [WORDS-1:0][`CFG_WORD_W-1:0] mem;
    logic [`CFG_WORD_W-1:0]            rdata;
  } store_state_s;

  store_state_s state_reg;
  store_state_s state_next;
  // The word array is flattened so that the struct takes its low bits.
  logic [WORDS*`CFG_WORD_W-1:0] mem_flat;

  always_comb
  begin
    state_next = state_reg;
    // Words past the end are ignored on write and read back as zero.
    if (wr_en && (32'(addr) < WORDS))
      state_next.mem[addr] = wr_data;
    if (32'(addr) < WORDS)
      state_next.rdata = state_reg.mem[addr];
    else
      state_next.rdata = `CFG_RESET;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign rd_data = state_reg.rdata;
  assign mem_flat = state_reg.mem;
  assign cfg      = mem_flat[CFG_BITS-1:0];

endmodule : cfg_store

// ===== design/hll_resolver.sv
// Resolves one horizontal long line from its bus drivers, pull-ups, keeper.
`timescale 1ns/100ps
`include "fabric_params.svh"

module hll_resolver (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic [`COLS-1:0]  drv_data,
  input  wire logic [`COLS-1:0]  drv_ctl_n,
  input  wire logic [`COLS-1:0]  drv_en,
  input  wire logic [1:0]        end_pull,
  output logic                   level,
  output logic                   contention
);

  typedef struct packed {
    logic keeper;
  } keeper_state_s;

  keeper_state_s    state_reg;
  keeper_state_s    state_next;
  logic [`COLS-1:0] active;
  logic             pull_low;
  logic             pull_high;

  always_comb
  begin
    active     = drv_en & ~drv_ctl_n;
    pull_low   = |(active & ~drv_data);
    pull_high  = |(active & drv_data);
    contention = 1'h0;
    state_next = state_reg;
    if (pull_low && pull_high)
    begin
      // Opposing drivers make the level undefined so simulation shows it.
      level      = 1'hx;
      contention = 1'h1;
    end
    else if (pull_low)
      level = 1'h0;
    else if (pull_high)
      level = 1'h1;
    else if (|end_pull)
      level = 1'h1;
    else
      level = state_reg.keeper;
    // A contended level is never stored; the keeper keeps its last value.
    if (!contention)
      state_next.keeper = level;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      state_reg <= '{keeper: `KEEPER_RESET};
    else
      state_reg <= state_next;
  end

  mux_pass_a: assert property (@(posedge clock) disable iff (rst)
    $onehot(active) |-> level == |(active & drv_data))
    else $error("Long line does not pass the one enabled driver.");

  pullup_high_a: assert property (@(posedge clock) disable iff (rst)
    (active == '0 && end_pull != 2'h0) |-> level)
    else $error("Pulled-up idle long line does not read high.");

  keeper_hold_a: assert property (@(posedge clock) disable iff (rst)
    (!contention && active == '0 && end_pull == 2'h0) ##1
    (active == '0 && end_pull == 2'h0) |-> level == $past(level))
    else $error("Keeper lost the level of an undriven long line.");

  open_drain_a: assert property (@(posedge clock) disable iff (rst)
    (|(drv_en & ~(drv_ctl_n ^ drv_data) & ~drv_data) && !pull_high)
    |-> !level)
    else $error("Open-drain driver failed to pull the line low.");

  tbuf_hiz_a: assert property (@(posedge clock) disable iff (rst)
    (|(drv_en & drv_ctl_n & ~drv_data) && active == '0 && end_pull != 2'h0)
    |-> level)
    else $error("Driver with control high disturbed the long line.");

endmodule : hll_resolver

// ===== design/routing_fabric.sv
// Programmable routing fabric: segments, direct links, long lines, clocks.
`timescale 1ns/100ps
`include "fabric_params.svh"

module routing_fabric (
  input  wire logic                   clock,
  input  wire logic                   rst,
  input  wire logic                   cfg_we,
  input  wire logic [`CFG_ADDR_W-1:0] cfg_addr,
  input  wire logic [`CFG_WORD_W-1:0] cfg_wdata,
  output logic      [`CFG_WORD_W-1:0] cfg_rdata,
  input  wire fabric_pkg::blk_out_t   blk_out,
  input  wire fabric_pkg::io_t        io_from_pad,
  input  wire logic                   gclk_in,
  input  wire logic                   aclk_in,
  output fabric_pkg::blk_in_t         blk_in,
  output fabric_pkg::io_t             io_to_pad,
  output fabric_pkg::edge_clk_t       edge_clk,
  output fabric_pkg::hll_t            hll_contention
);

  localparam int HALF = `ROWS / 2;

  typedef struct packed {
    logic [`ROWS-1:0][`TRACKS-1:0][`COLS-1:0] hseg;
    logic [`COLS-1:0][`TRACKS-1:0][`ROWS-1:0] vseg;
    fabric_pkg::blk_in_t                      blk_in;
    fabric_pkg::io_t                          io_out;
    fabric_pkg::edge_clk_t                    edge_clk;
    fabric_pkg::hll_t                         contention;
  } fabric_state_s;

  fabric_state_s                           state_reg;
  fabric_state_s                           state_next;
  fabric_pkg::config_s                     cfg;
  logic [`COLS-1:0][`VLONG-1:0][`ROWS-1:0] vll;
  fabric_pkg::hll_t                        hll_level;
  fabric_pkg::hll_t                        hll_cont;

  function automatic int lo(input int i);
    return (i > 0) ? i - 1 : 0;
  endfunction : lo

  function automatic int hi(input int i, input int n);
    return (i < n - 1) ? i + 1 : i;
  endfunction : hi

  // Only some vertical lines have a split point; the rest ignore the bit.
  function automatic logic split_ok(input int c, input int l,
                                    input logic [`SPLIT_LINES-1:0] split);
    if (l >= `SPLIT_LINES)
      return 1'h0;
    if (`SMALLEST_ARRAY && c != 0 && c != `COLS - 1)
      return 1'h0;
    return split[l[0]];
  endfunction : split_ok

  cfg_store u_cfg_store (
    .clock   (clock),
    .rst     (rst),
    .wr_en   (cfg_we),
    .addr    (cfg_addr),
    .wr_data (cfg_wdata),
    .rd_data (cfg_rdata),
    .cfg     (cfg)
  );

  for (genvar gr = 0; gr < `ROWS; gr++)
  begin : g_row
    for (genvar gl = 0; gl < `HLONG; gl++)
    begin : g_hll
      logic [`COLS-1:0] drv_data;
      logic [`COLS-1:0] drv_ctl_n;
      logic [`COLS-1:0] drv_en;
      for (genvar gc = 0; gc < `COLS; gc++)
      begin : g_drv
        // Each block's driver gl sits on long line gl of its own row.
        assign drv_data[gc]  = blk_out[gr][gc].tbuf_data[gl];
        assign drv_ctl_n[gc] = blk_out[gr][gc].tbuf_ctl_n[gl];
        assign drv_en[gc]    = cfg.blk[gr][gc].tbuf_use[gl];
      end
      hll_resolver u_res (
        .clock      (clock),
        .rst        (rst),
        .drv_data   (drv_data),
        .drv_ctl_n  (drv_ctl_n),
        .drv_en     (drv_en),
        .end_pull   (cfg.row[gr].end_pull[gl]),
        .level      (hll_level[gr][gl]),
        .contention (hll_cont[gr][gl])
      );
    end
  end

  always_comb
  begin
    logic       v;
    logic [2:0] idx;
    v          = 1'h0;
    idx        = 3'h0;
    state_next = state_reg;
    // Vertical long lines bypass the matrices and are computed directly.
    for (int c = 0; c < `COLS; c++)
      for (int l = 0; l < `VLONG; l++)
        for (int r = 0; r < `ROWS; r++)
        begin
          vll[c][l][r] = (l == `ALT_VLONG) && cfg.col[c].alt_link
                         && aclk_in;
          for (int d = 0; d < `ROWS; d++)
          begin
            case (cfg.blk[d][c].vll_src)
              fabric_pkg::VLL_FROM_X:  v = blk_out[d][c].x;
              fabric_pkg::VLL_FROM_Y:  v = blk_out[d][c].y;
              fabric_pkg::VLL_FROM_IO: v = io_from_pad[`EDGE_TOP][c];
              default:                 v = 1'h0;
            endcase
            if (cfg.blk[d][c].vll_en && cfg.blk[d][c].vll_line == 2'(l)
                && (!split_ok(c, l, cfg.col[c].split)
                    || ((d < HALF) == (r < HALF))))
              vll[c][l][r] = vll[c][l][r] | v;
          end
        end
    // Segments are registered hop by hop, so bidirectional chains and
    // matrix loops can never form a combinational loop.
    for (int r = 0; r < `ROWS; r++)
      for (int t = 0; t < `TRACKS; t++)
        for (int c = 0; c < `COLS; c++)
        begin
          case (cfg.blk[r][c].hseg[t])
            fabric_pkg::SEG_FROM_LOW:
              v = (c > 0) && state_reg.hseg[r][t][lo(c)];
            fabric_pkg::SEG_FROM_HIGH:
              v = (c < `COLS - 1) && state_reg.hseg[r][t][hi(c, `COLS)];
            fabric_pkg::SEG_FROM_X:     v = blk_out[r][c].x;
            fabric_pkg::SEG_FROM_Y:     v = blk_out[r][c].y;
            fabric_pkg::SEG_FROM_CROSS: v = state_reg.vseg[c][t][r];
            default:                    v = 1'h0;
          endcase
          state_next.hseg[r][t][c] = v;
          case (cfg.blk[r][c].vseg[t])
            fabric_pkg::SEG_FROM_LOW:
              v = (r > 0) && state_reg.vseg[c][t][lo(r)];
            fabric_pkg::SEG_FROM_HIGH:
              v = (r < `ROWS - 1) && state_reg.vseg[c][t][hi(r, `ROWS)];
            fabric_pkg::SEG_FROM_X:     v = blk_out[r][c].x;
            fabric_pkg::SEG_FROM_Y:     v = blk_out[r][c].y;
            fabric_pkg::SEG_FROM_CROSS: v = state_reg.hseg[r][t][c];
            default:                    v = 1'h0;
          endcase
          state_next.vseg[c][t][r] = v;
        end
    // Block inputs: direct neighbours, edge I/O, segments or long lines.
    for (int r = 0; r < `ROWS; r++)
      for (int c = 0; c < `COLS; c++)
      begin
        for (int p = 0; p < `PINS; p++)
        begin
          case (p)
            `PIN_A: v = (r > 0) ? blk_out[lo(r)][c].y
                      : (c % 2 == 0) && io_from_pad[`EDGE_TOP][c];
            `PIN_B: v = (c > 0) ? blk_out[r][lo(c)].x
                      : (r % 2 == 0) && io_from_pad[`EDGE_LEFT][r];
            `PIN_C: v = (c < `COLS - 1) ? blk_out[r][hi(c, `COLS)].x
                      : (r % 2 == 0) && io_from_pad[`EDGE_RIGHT][r];
            default: v = (r < `ROWS - 1) ? blk_out[hi(r, `ROWS)][c].y
                       : (c % 2 == 0) && io_from_pad[`EDGE_BOTTOM][c];
          endcase
          idx = cfg.blk[r][c].pin[p].idx;
          case (cfg.blk[r][c].pin[p].src)
            fabric_pkg::PIN_DIRECT: state_next.blk_in[r][c].pin[p] = v;
            fabric_pkg::PIN_HSEG:
              state_next.blk_in[r][c].pin[p] = (idx < 3'(`TRACKS))
                && state_reg.hseg[r][(idx < 3'(`TRACKS)) ? idx : 3'h0][c];
            fabric_pkg::PIN_LONG:
              // The two indices past the vertical lines select the row's
              // horizontal long lines; higher indices read zero.
              if (idx < 3'(`VLONG))
                state_next.blk_in[r][c].pin[p] = vll[c][idx][r];
              else if (idx < 3'(`VLONG + `HLONG))
                state_next.blk_in[r][c].pin[p] =
                  hll_level[r][idx[0] ^ 1'h1];
              else
                state_next.blk_in[r][c].pin[p] = 1'h0;
            default: state_next.blk_in[r][c].pin[p] = 1'h0;
          endcase
        end
        case (cfg.blk[r][c].clk)
          fabric_pkg::CLK_GLOBAL:
            state_next.blk_in[r][c].k = gclk_in;
          fabric_pkg::CLK_ALTERNATE:
            state_next.blk_in[r][c].k = vll[c][`ALT_VLONG][r];
          fabric_pkg::CLK_COLUMN:
            state_next.blk_in[r][c].k = vll[c][`COLUMN_VLONG][r];
          default:
            state_next.blk_in[r][c].k = 1'h0;
        endcase
      end
    // Edge outputs: odd positions take a direct link, the right edge all.
    for (int i = 0; i < `IO_PER_EDGE; i++)
    begin
      state_next.io_out[`EDGE_TOP][i] = cfg.edges[`EDGE_TOP].io_direct[i]
        && (i % 2 == 1) && blk_out[0][i].y;
      state_next.io_out[`EDGE_BOTTOM][i] =
        cfg.edges[`EDGE_BOTTOM].io_direct[i] && (i % 2 == 1)
        && blk_out[`ROWS-1][i].y;
      state_next.io_out[`EDGE_LEFT][i] = cfg.edges[`EDGE_LEFT].io_direct[i]
        && (i % 2 == 1) && blk_out[i][0].x;
      state_next.io_out[`EDGE_RIGHT][i] =
        cfg.edges[`EDGE_RIGHT].io_direct[i] && blk_out[i][`COLS-1].x;
    end
    for (int e = 0; e < `EDGES; e++)
      for (int j = 0; j < `EDGE_CLKS; j++)
        state_next.edge_clk[e][j] =
          cfg.edges[e].gclk_drive[j] && gclk_in;
    // Contention is only flagged; avoiding it is up to the user logic.
    state_next.contention = hll_cont;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign blk_in         = state_reg.blk_in;
  assign io_to_pad      = state_reg.io_out;
  assign edge_clk       = state_reg.edge_clk;
  assign hll_contention = state_reg.contention;

  switches_open_a: assert property (@(posedge clock) disable iff (rst)
    (cfg == '0) ##1 (cfg == '0) |-> (state_reg.hseg == '0
      && state_reg.vseg == '0 && state_reg.blk_in == '0))
    else $error("Unprogrammed fabric passed a signal.");

  bidi_east_a: assert property (@(posedge clock) disable iff (rst)
    (cfg.blk[0][1].hseg[0] == fabric_pkg::SEG_FROM_LOW)
    |=> state_reg.hseg[0][0][1] == $past(state_reg.hseg[0][0][0]))
    else $error("Segment buffer did not pass eastward.");

  direct_right_a: assert property (@(posedge clock) disable iff (rst)
    (cfg.blk[1][2].pin[`PIN_B].src == fabric_pkg::PIN_DIRECT)
    |=> state_reg.blk_in[1][2].pin[`PIN_B] == $past(blk_out[1][1].x))
    else $error("Left neighbour output missed the direct input.");

  direct_up_a: assert property (@(posedge clock) disable iff (rst)
    (cfg.blk[0][1].pin[`PIN_D].src == fabric_pkg::PIN_DIRECT)
    |=> state_reg.blk_in[0][1].pin[`PIN_D] == $past(blk_out[1][1].y))
    else $error("Lower neighbour output missed the direct input.");

  global_clock_a: assert property (@(posedge clock) disable iff (rst)
    (cfg.blk[2][2].clk == fabric_pkg::CLK_GLOBAL)
    |=> blk_in[2][2].k == $past(gclk_in))
    else $error("Block clock does not follow the global net.");

  edge_clock_a: assert property (@(posedge clock) disable iff (rst)
    cfg.edges[`EDGE_LEFT].gclk_drive[0]
    |=> edge_clk[`EDGE_LEFT][0] == $past(gclk_in))
    else $error("Edge clock line does not follow the global net.");

  contention_flag_a: assert property (@(posedge clock) disable iff (rst)
    hll_cont[3][0] |=> hll_contention[3][0])
    else $error("Long line contention was not flagged.");

endmodule : routing_fabric

// ===== testbench/block_array_model.sv
// Behavioural array of logic blocks that feeds the block outputs into the fabric.
`timescale 1ns/100ps
`include "fabric_params.svh"

module block_array_model (
  input  wire fabric_pkg::blk_out_t req,
  input  wire logic                 allow_clash,
  output fabric_pkg::blk_out_t      blk_out
);
  // A later driver that would oppose the level already on its line is held
  // off, as careful user logic would; a scenario may lift this on purpose.
  always_comb
  begin
    logic [`ROWS-1:0][`HLONG-1:0] taken;
    logic [`ROWS-1:0][`HLONG-1:0] lvl;
    blk_out = req;
    taken = '0;
    lvl = '0;
    for (int r = 0; r < `ROWS; r++)
      for (int c = 0; c < `COLS; c++)
        for (int l = 0; l < `HLONG; l++)
        begin
          if (!req[r][c].tbuf_ctl_n[l])
          begin
            if (taken[r][l] && !allow_clash
                && lvl[r][l] != req[r][c].tbuf_data[l])
              blk_out[r][c].tbuf_ctl_n[l] = 1'h1;
            else
            begin
              taken[r][l] = 1'h1;
              lvl[r][l] = req[r][c].tbuf_data[l];
            end
          end
        end
  end
endmodule : block_array_model

// ===== testbench/routing_fabric_tb.sv
// Self-checking bench for the routing fabric with a queued scoreboard.
`timescale 1ns/100ps
`include "fabric_params.svh"

`define CHECK(nm, exp, got) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) \
    begin \
      errors++; \
      $display("Error %s expected %h seen %h", nm, exp, got); \
    end \
  end

module routing_fabric_tb;
  typedef struct {int due; int pos; logic b; string nm;} note_s;
  logic                   clock;
  logic                   rst;
  logic                   cfg_we;
  logic [`CFG_ADDR_W-1:0] cfg_addr;
  logic [`CFG_WORD_W-1:0] cfg_wdata;
  fabric_pkg::blk_out_t   req;
  fabric_pkg::blk_out_t   blk_out;
  fabric_pkg::io_t        io_from_pad;
  logic                   gclk_in;
  logic                   aclk_in;
  logic                   allow_clash;
  fabric_pkg::blk_in_t    blk_in;
  fabric_pkg::io_t        io_to_pad;
  fabric_pkg::edge_clk_t  edge_clk;
  fabric_pkg::hll_t       hll_contention;
  fabric_pkg::config_s    cfg;
  int                     errors;
  int                     n_checks;
  int                     cyc;
  int                     seed;
  note_s                  notes[$];
  wire logic [111:0]      obs = {blk_in, io_to_pad, edge_clk, hll_contention};

  block_array_model partner_u (.req(req), .allow_clash(allow_clash),
    .blk_out(blk_out));
  routing_fabric dut_u (.clock(clock), .rst(rst), .cfg_we(cfg_we),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(),
    .blk_out(blk_out), .io_from_pad(io_from_pad), .gclk_in(gclk_in),
    .aclk_in(aclk_in), .blk_in(blk_in), .io_to_pad(io_to_pad),
    .edge_clk(edge_clk), .hll_contention(hll_contention));

  initial
  begin
    clock = 1'h0;
    forever #50 clock = ~clock;
  end

  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    io_from_pad <= 16'($random(seed));
  end

  // Results land on the edge that samples the driven inputs and are compared at the negedge after it.
  always @(negedge clock)
    while (notes.size() > 0 && notes[0].due <= cyc)
    begin
      `CHECK(notes[0].nm, notes[0].b, obs[notes[0].pos])
      void'(notes.pop_front());
    end

  function automatic int blk_pos(int r, int c);
    return 32 + (r * 4 + c) * 5;
  endfunction : blk_pos

  // A segment path adds one cycle per hop, so callers give the latency.
  task automatic note_bit(string nm, int pos, logic b, int lat = 1);
    notes.push_back('{cyc + 1 + lat, pos, b, nm});
  endtask : note_bit

  task automatic load_cfg();
    logic [1007:0] flat;
    flat = {12'h000, cfg};
    for (int k = 0; k < 63; k++)
    begin
      @(posedge clock);
      cfg_we <= 1'h1;
      cfg_addr <= 6'(k);
      cfg_wdata <= flat[16*k +: 16];
    end
    @(posedge clock);
    cfg_we <= 1'h0;
    repeat (3) @(posedge clock);
  endtask : load_cfg

  task automatic bus_case(logic [5:0] v);
    @(posedge clock);
    allow_clash <= v[5];
    req[3][1].tbuf_data[0] <= v[4];
    req[3][1].tbuf_ctl_n[0] <= v[3];
    req[3][2].tbuf_data[0] <= v[2];
    req[3][2].tbuf_ctl_n[0] <= v[1];
    note_bit("bus_pin", blk_pos(3, 0) + 1, v[5] ? 1'hX : v[0]);
    note_bit("clash", 6, v[5]);
  endtask : bus_case

  task automatic wrap_up();
    // A note that never came due means a result was never compared.
    if (notes.size() != 0)
      errors++;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  initial
  begin
    repeat (3000) @(posedge clock);
    errors++;
    wrap_up();
  end

  initial
  begin
    logic [7:0] v;
    seed = 32'h5CB3F1D4;
    {rst, cfg_we, cfg_addr, cfg_wdata, gclk_in, aclk_in} = '0;
    rst = 1'h1;
    io_from_pad = '0;
    allow_clash = 1'h0;
    cyc = 0;
    req = '1;
    repeat (20) @(posedge clock);
    rst <= 1'h0;
    repeat (4)
    begin
      @(negedge clock);
      `CHECK("idle", 112'h0, obs)
    end
    cfg = '0;
    cfg.blk[1][2].pin[`PIN_B].src = fabric_pkg::PIN_DIRECT;
    cfg.blk[1][0].pin[`PIN_C].src = fabric_pkg::PIN_DIRECT;
    cfg.blk[0][1].pin[`PIN_D].src = fabric_pkg::PIN_DIRECT;
    cfg.blk[2][1].pin[`PIN_A].src = fabric_pkg::PIN_DIRECT;
    cfg.blk[2][2].clk = fabric_pkg::CLK_GLOBAL;
    cfg.edges[`EDGE_LEFT].gclk_drive[0] = 1'h1;
    cfg.edges[`EDGE_RIGHT].io_direct[2] = 1'h1;
    cfg.blk[1][2].vll_en = 1'h1;
    cfg.blk[1][2].vll_line = 2'h1;
    cfg.blk[1][2].vll_src = fabric_pkg::VLL_FROM_Y;
    cfg.col[2].split = 2'h2;
    cfg.blk[0][2].pin[`PIN_C] = '{fabric_pkg::PIN_LONG, 3'h1};
    cfg.blk[3][2].pin[`PIN_C] = '{fabric_pkg::PIN_LONG, 3'h1};
    cfg.col[1].alt_link = 1'h1;
    cfg.blk[3][1].clk = fabric_pkg::CLK_ALTERNATE;
    cfg.blk[0][0].hseg[0] = fabric_pkg::SEG_FROM_X;
    cfg.blk[0][1].hseg[0] = fabric_pkg::SEG_FROM_LOW;
    cfg.blk[0][1].pin[`PIN_B] = '{fabric_pkg::PIN_HSEG, 3'h0};
    load_cfg();
    repeat (16)
    begin
      @(posedge clock);
      v = 8'($random(seed));
      req[1][1].x <= v[0];
      req[1][1].y <= v[1];
      gclk_in <= v[2];
      req[2][3].x <= v[3];
      req[1][2].y <= v[4];
      aclk_in <= v[5];
      note_bit("vll_top", blk_pos(0, 2) + 3, v[4]);
      note_bit("vll_split", blk_pos(3, 2) + 3, 1'h0);
      note_bit("k_alt", blk_pos(3, 1), v[5]);
      note_bit("x_right", blk_pos(1, 2) + 2, v[0]);
      note_bit("x_left", blk_pos(1, 0) + 3, v[0]);
      note_bit("y_up", blk_pos(0, 1) + 4, v[1]);
      note_bit("y_down", blk_pos(2, 1) + 1, v[1]);
      note_bit("k_global", blk_pos(2, 2), v[2]);
      note_bit("edge_clk", 8 + `EDGE_LEFT * 2, v[2]);
      note_bit("io_right", 16 + `EDGE_RIGHT * 4 + 2, v[3]);
      note_bit("open_pin", blk_pos(1, 2) + 3, 1'h0);
    end
    // Source to segment, segment to segment, segment to pin: three hops.
    repeat (8)
    begin
      @(posedge clock);
      v = 8'($random(seed));
      req[0][0].x <= v[0];
      note_bit("seg_east", blk_pos(0, 1) + 2, v[0], 3);
    end
    cfg.blk[3][1].tbuf_use[0] = 1'h1;
    cfg.blk[3][2].tbuf_use[0] = 1'h1;
    cfg.blk[3][0].pin[`PIN_A] = '{fabric_pkg::PIN_LONG, 3'h3};
    cfg.row[3].end_pull[0] = 2'h1;
    load_cfg();
    bus_case(6'h0B);
    bus_case(6'h02);
    bus_case(6'h13);
    bus_case(6'h08);
    bus_case(6'h06);
    bus_case(6'h00);
    bus_case(6'h24);
    bus_case(6'h0B);
    cfg.row[3].end_pull[0] = 2'h0;
    load_cfg();
    bus_case(6'h13);
    bus_case(6'h1B);
    bus_case(6'h02);
    bus_case(6'h0A);
    repeat (4) @(posedge clock);
    wrap_up();
  end
endmodule : routing_fabric_tb
